// File: shared/core_pkg.sv
package core_pkg;

    // ****************************************
    // Widths and sizes
    // ****************************************
    localparam int INSN_W = 14;
    localparam int DATA_W = 8;
    localparam int NIB_W = 4;
    // A 12-bit counter reaches 4K program words and wraps at the top.
    localparam int PC_W = 12;
    localparam int RAM_DEPTH = 192;
    localparam int FILE_W = 7;
    localparam int LATCH_W = 5;
    localparam int JUMP_W = 11;
    localparam int SYNC_LEN = 3;

    // ****************************************
    // Instruction word fields
    // ****************************************
    localparam int CLS_MSB = 13;
    localparam int CLS_LSB = 12;
    localparam int OP_MSB = 11;
    localparam int OP_LSB = 8;
    localparam int DEST_BIT = 7;
    localparam int BSEL_MSB = 9;
    localparam int BSEL_LSB = 7;
    localparam int LIT_MSB = 7;

    localparam logic [1:0] CLS_BYTE = 2'h0;
    localparam logic [1:0] CLS_BIT = 2'h1;
    localparam logic [1:0] CLS_JUMP = 2'h2;
    localparam logic [1:0] CLS_LIT = 2'h3;

    localparam logic [3:0] OP_MOVWF = 4'h0;
    localparam logic [3:0] OP_CLR = 4'h1;
    localparam logic [3:0] OP_SUB = 4'h2;
    localparam logic [3:0] OP_DEC = 4'h3;
    localparam logic [3:0] OP_IOR = 4'h4;
    localparam logic [3:0] OP_AND = 4'h5;
    localparam logic [3:0] OP_XOR = 4'h6;
    localparam logic [3:0] OP_ADD = 4'h7;
    localparam logic [3:0] OP_MOV = 4'h8;
    localparam logic [3:0] OP_COM = 4'h9;
    localparam logic [3:0] OP_INC = 4'hA;
    localparam logic [3:0] OP_DECSZ = 4'hB;
    localparam logic [3:0] OP_RRF = 4'hC;
    localparam logic [3:0] OP_RLF = 4'hD;
    localparam logic [3:0] OP_SWAP = 4'hE;
    localparam logic [3:0] OP_INCSZ = 4'hF;

    localparam logic [1:0] BOP_CLR = 2'h0;
    localparam logic [1:0] BOP_SET = 2'h1;
    localparam logic [1:0] BOP_TSTC = 2'h2;
    localparam logic [1:0] BOP_TSTS = 2'h3;

    localparam logic [3:0] LIT_IOR = 4'h8;
    localparam logic [3:0] LIT_AND = 4'h9;
    localparam logic [3:0] LIT_XOR = 4'hA;
    localparam logic [2:0] LIT_SUB = 3'h6;
    localparam logic [2:0] LIT_ADD = 3'h7;

    // ****************************************
    // Data memory map
    // ****************************************
    localparam logic [FILE_W-1:0] ADDR_INDIRECT = 7'h00;
    localparam logic [FILE_W-1:0] ADDR_PC_LOW = 7'h02;
    localparam logic [FILE_W-1:0] ADDR_STATUS = 7'h03;
    localparam logic [FILE_W-1:0] ADDR_FILE_SEL = 7'h04;
    localparam logic [FILE_W-1:0] ADDR_PC_LATCH = 7'h0A;
    localparam logic [FILE_W-1:0] ADDR_GPR_BASE = 7'h20;
    localparam logic [DATA_W-1:0] GPR_PER_BANK = 8'h60;

    localparam int ST_CARRY = 0;
    localparam int ST_NIBBLE = 1;
    localparam int ST_ZERO = 2;
    localparam int ST_BANK = 5;
    localparam logic [DATA_W-1:0] STATUS_WRITABLE = 8'h27;

    typedef enum logic [1:0] {PHASE_ONE, PHASE_TWO, PHASE_THREE, PHASE_FOUR} phase_t;

    typedef enum logic [3:0] {
        ALU_ADD, ALU_SUB, ALU_AND, ALU_IOR, ALU_XOR, ALU_COM, ALU_INC, ALU_DEC,
        ALU_RLF, ALU_RRF, ALU_SWAP, ALU_PASS_A, ALU_PASS_B, ALU_CLEAR, ALU_BCLR, ALU_BSET
    } alu_op_t;

endpackage : core_pkg

// File: core/alu_unit.sv
`timescale 1ns/100ps
module alu_unit (
    input wire core_pkg::alu_op_t op,
    input wire logic [core_pkg::DATA_W-1:0] a,
    input wire logic [core_pkg::DATA_W-1:0] b,
    input wire logic [2:0] bitSel,
    input wire logic carryIn,
    output logic [core_pkg::DATA_W-1:0] result,
    output logic carryOut,
    output logic nibbleOut,
    output logic zeroOut
);
    import core_pkg::*;

    logic [DATA_W:0] sum;
    logic [NIB_W:0] nibSum;
    logic [DATA_W-1:0] addend;
    logic [DATA_W-1:0] mask;

    always_comb begin
        // Subtraction is b plus the two's complement of a, so carry high means no borrow.
        addend = (op == ALU_SUB) ? ~a : a;
        sum = {1'b0, b} + {1'b0, addend} + {{DATA_W{1'b0}}, op == ALU_SUB};
        nibSum = {1'b0, b[NIB_W-1:0]} + {1'b0, addend[NIB_W-1:0]}
            + {{NIB_W{1'b0}}, op == ALU_SUB};
        mask = 8'h01 << bitSel;
        carryOut = carryIn;
        nibbleOut = nibSum[NIB_W];
        unique case (op)
            ALU_ADD, ALU_SUB: begin
                result = sum[DATA_W-1:0];
                carryOut = sum[DATA_W];
            end
            ALU_AND: result = a & b;
            ALU_IOR: result = a | b;
            ALU_XOR: result = a ^ b;
            ALU_COM: result = ~b;
            ALU_INC: result = b + 8'h01;
            ALU_DEC: result = b - 8'h01;
            ALU_RLF: begin
                result = {b[DATA_W-2:0], carryIn};
                carryOut = b[DATA_W-1];
            end
            ALU_RRF: begin
                result = {carryIn, b[DATA_W-1:1]};
                carryOut = b[0];
            end
            ALU_SWAP: result = {b[NIB_W-1:0], b[DATA_W-1:NIB_W]};
            ALU_PASS_A: result = a;
            ALU_PASS_B: result = b;
            ALU_CLEAR: result = '0;
            ALU_BCLR: result = b & ~mask;
            ALU_BSET: result = b | mask;
        endcase
        zeroOut = (result == '0);
    end

endmodule : alu_unit

// File: core/exec_core.sv
`timescale 1ns/100ps
// Operation
// - Fetch one 14-bit word per cycle.
// - Fetch overlaps execute; branches take two cycles.
// - 8-bit unit adds, subtracts, shifts, logic.
// - Arithmetic results are two's complement.
// - Two operands: accumulator plus file or literal.
// - One operand: accumulator or file register.
// - Accumulator is 8 bits, has no address.
// - Instructions update carry, nibble and zero flags.
// - Subtraction uses carry flags as borrow indicators.
// - Core registers and counter live in data memory.
// - Every operation works on every register.
// - 4K program words, 192 data bytes.
// - Resistor-capacitor mode: cycle output at quarter rate.
// - Low master clear resets the device.
// - Input divided into four phases per cycle.
// - Operand read phase two, written phase four.
module exec_core (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic masterClearN,
    input wire logic resistorCapacitorOscMode,
    input wire logic [core_pkg::INSN_W-1:0] progData,
    output logic [core_pkg::PC_W-1:0] progAddr,
    output logic cycleRateOutput,
    output logic [core_pkg::DATA_W-1:0] workingReg,
    output logic [core_pkg::DATA_W-1:0] statusReg
);
    import core_pkg::*;

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic [SYNC_LEN-1:0] clearSync;
        logic [SYNC_LEN-1:0] oscModeSync;
        logic inClear;
        logic oscMode;
        phase_t phase;
        logic [PC_W-1:0] pc;
        logic [INSN_W-1:0] execIr;
        logic execValid;
        logic [DATA_W-1:0] operand;
        logic [DATA_W-1:0] w;
        logic [DATA_W-1:0] status;
        logic [DATA_W-1:0] fileSelect;
        logic [LATCH_W-1:0] pcLatch;
        logic cycleRate;
        logic [RAM_DEPTH-1:0][DATA_W-1:0] ram;
    } core_state_t;

    core_state_t st;
    core_state_t next_st;

    // Kept as plain bits so the decode can fill it inside concatenations.
    logic [$bits(alu_op_t)-1:0] aluOp;
    logic [DATA_W-1:0] aluResult;
    logic aluCarry;
    logic aluNibble;
    logic aluZero;
    logic toW;
    logic toFile;
    logic setC;
    logic setNibble;
    logic setZ;
    logic skipOnZero;
    logic isLiteral;
    logic redirect;
    logic skipNext;
    logic [PC_W-1:0] target;
    logic [DATA_W-1:0] addr;

    function automatic logic [DATA_W-1:0] ramIndex(input logic [DATA_W-1:0] a);
        logic [FILE_W-1:0] offset;
        offset = a[FILE_W-1:0] - ADDR_GPR_BASE;
        return {1'b0, offset} + (a[DATA_W-1] ? GPR_PER_BANK : '0);
    endfunction : ramIndex

    // Core registers answer in both banks; locations with no register read as zero.
    function automatic logic [DATA_W-1:0] readFile(input logic [DATA_W-1:0] a,
                                                    input core_state_t s);
        unique case (a[FILE_W-1:0])
            ADDR_INDIRECT: return '0;
            ADDR_PC_LOW: return s.pc[DATA_W-1:0];
            ADDR_STATUS: return s.status;
            ADDR_FILE_SEL: return s.fileSelect;
            ADDR_PC_LATCH: return {{(DATA_W-LATCH_W){1'b0}}, s.pcLatch};
            default: return (a[FILE_W-1:0] >= ADDR_GPR_BASE) ? s.ram[ramIndex(a)] : '0;
        endcase
    endfunction : readFile

    alu_unit u_alu (
        .op(alu_op_t'(aluOp)),
        .a(st.w),
        .b(st.operand),
        .bitSel(st.execIr[BSEL_MSB:BSEL_LSB]),
        .carryIn(st.status[ST_CARRY]),
        .result(aluResult),
        .carryOut(aluCarry),
        .nibbleOut(aluNibble),
        .zeroOut(aluZero)
    );

    // ****************************************
    // Decode and execute
    // ****************************************
    always_comb begin
        next_st = st;
        aluOp = ALU_PASS_B;
        toW = 1'b0;
        toFile = 1'b0;
        setC = 1'b0;
        setNibble = 1'b0;
        setZ = 1'b0;
        skipOnZero = 1'b0;
        isLiteral = 1'b0;
        redirect = 1'b0;
        skipNext = 1'b0;
        target = st.pc + 12'h001;
        // A file field of zero goes through the pointer, so any register is reachable.
        addr = (st.execIr[FILE_W-1:0] == ADDR_INDIRECT) ? st.fileSelect
            : {st.status[ST_BANK], st.execIr[FILE_W-1:0]};

        unique case (st.execIr[CLS_MSB:CLS_LSB])
            CLS_BYTE: begin
                toW = ~st.execIr[DEST_BIT];
                toFile = st.execIr[DEST_BIT];
                unique case (st.execIr[OP_MSB:OP_LSB])
                    OP_MOVWF: begin
                        aluOp = ALU_PASS_A;
                        toW = 1'b0;
                    end
                    OP_CLR: begin
                        aluOp = ALU_CLEAR;
                        setZ = 1'b1;
                    end
                    OP_SUB: begin
                        aluOp = ALU_SUB;
                        {setC, setNibble, setZ} = 3'h7;
                    end
                    OP_ADD: begin
                        aluOp = ALU_ADD;
                        {setC, setNibble, setZ} = 3'h7;
                    end
                    OP_DEC: {aluOp, setZ} = {ALU_DEC, 1'b1};
                    OP_IOR: {aluOp, setZ} = {ALU_IOR, 1'b1};
                    OP_AND: {aluOp, setZ} = {ALU_AND, 1'b1};
                    OP_XOR: {aluOp, setZ} = {ALU_XOR, 1'b1};
                    OP_MOV: {aluOp, setZ} = {ALU_PASS_B, 1'b1};
                    OP_COM: {aluOp, setZ} = {ALU_COM, 1'b1};
                    OP_INC: {aluOp, setZ} = {ALU_INC, 1'b1};
                    OP_DECSZ: {aluOp, skipOnZero} = {ALU_DEC, 1'b1};
                    OP_INCSZ: {aluOp, skipOnZero} = {ALU_INC, 1'b1};
                    OP_RRF: {aluOp, setC} = {ALU_RRF, 1'b1};
                    OP_RLF: {aluOp, setC} = {ALU_RLF, 1'b1};
                    OP_SWAP: aluOp = ALU_SWAP;
                endcase
            end
            CLS_BIT: begin
                unique case (st.execIr[OP_MSB:BSEL_MSB+1])
                    BOP_CLR: {aluOp, toFile} = {ALU_BCLR, 1'b1};
                    BOP_SET: {aluOp, toFile} = {ALU_BSET, 1'b1};
                    BOP_TSTC: skipNext = ~st.operand[st.execIr[BSEL_MSB:BSEL_LSB]];
                    BOP_TSTS: skipNext = st.operand[st.execIr[BSEL_MSB:BSEL_LSB]];
                endcase
            end
            CLS_JUMP: begin
                redirect = 1'b1;
                target = {st.pcLatch[PC_W-JUMP_W-1+NIB_W-1], st.execIr[JUMP_W-1:0]};
            end
            CLS_LIT: begin
                isLiteral = 1'b1;
                toW = 1'b1;
                if (st.execIr[OP_MSB] == 1'b0) begin
                    aluOp = ALU_PASS_B;
                end else if (st.execIr[OP_MSB:OP_LSB+1] == LIT_SUB) begin
                    aluOp = ALU_SUB;
                    {setC, setNibble, setZ} = 3'h7;
                end else if (st.execIr[OP_MSB:OP_LSB+1] == LIT_ADD) begin
                    aluOp = ALU_ADD;
                    {setC, setNibble, setZ} = 3'h7;
                end else if (st.execIr[OP_MSB:OP_LSB] == LIT_IOR) begin
                    {aluOp, setZ} = {ALU_IOR, 1'b1};
                end else if (st.execIr[OP_MSB:OP_LSB] == LIT_AND) begin
                    {aluOp, setZ} = {ALU_AND, 1'b1};
                end else if (st.execIr[OP_MSB:OP_LSB] == LIT_XOR) begin
                    {aluOp, setZ} = {ALU_XOR, 1'b1};
                end
            end
        endcase

        // Three-stage pin synchronisers; a level counts once stages two and three agree.
        next_st.clearSync = {st.clearSync[SYNC_LEN-2:0], masterClearN};
        next_st.oscModeSync = {st.oscModeSync[SYNC_LEN-2:0], resistorCapacitorOscMode};
        if (st.clearSync[1] == st.clearSync[2]) begin
            next_st.inClear = ~st.clearSync[2];
        end
        if (st.oscModeSync[1] == st.oscModeSync[2]) begin
            next_st.oscMode = st.oscModeSync[2];
        end

        unique case (st.phase)
            PHASE_ONE: next_st.phase = PHASE_TWO;
            PHASE_TWO: begin
                next_st.phase = PHASE_THREE;
                next_st.operand = isLiteral ? st.execIr[LIT_MSB:0] : readFile(addr, st);
            end
            PHASE_THREE: next_st.phase = PHASE_FOUR;
            PHASE_FOUR: begin
                next_st.phase = PHASE_ONE;
                if (st.execValid) begin
                    skipNext = skipNext | (skipOnZero & aluZero);
                    if (toW) begin
                        next_st.w = aluResult;
                    end
                    if (toFile) begin
                        unique case (addr[FILE_W-1:0])
                            ADDR_INDIRECT: ;
                            ADDR_PC_LOW: begin
                                redirect = 1'b1;
                                target = {st.pcLatch[NIB_W-1:0], aluResult};
                            end
                            ADDR_STATUS: next_st.status = aluResult & STATUS_WRITABLE;
                            ADDR_FILE_SEL: next_st.fileSelect = aluResult;
                            ADDR_PC_LATCH: next_st.pcLatch = aluResult[LATCH_W-1:0];
                            default: begin
                                if (addr[FILE_W-1:0] >= ADDR_GPR_BASE) begin
                                    next_st.ram[ramIndex(addr)] = aluResult;
                                end
                            end
                        endcase
                    end
                    // Flag updates win over a direct write of the same status bits.
                    if (setC) next_st.status[ST_CARRY] = aluCarry;
                    if (setNibble) next_st.status[ST_NIBBLE] = aluNibble;
                    if (setZ) next_st.status[ST_ZERO] = aluZero;
                end else begin
                    redirect = 1'b0;
                    skipNext = 1'b0;
                end
                // The word fetched this cycle is dropped when flow changes.
                next_st.execIr = progData;
                next_st.execValid = ~(redirect | skipNext);
                next_st.pc = redirect ? target : st.pc + 12'h001;
            end
        endcase

        if (st.inClear) begin
            next_st.phase = PHASE_ONE;
            next_st.pc = '0;
            next_st.execValid = 1'b0;
            next_st.w = '0;
            next_st.status = '0;
            next_st.fileSelect = '0;
            next_st.pcLatch = '0;
        end
        next_st.cycleRate = next_st.oscMode &
            (next_st.phase == PHASE_THREE || next_st.phase == PHASE_FOUR);
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign progAddr = st.pc;
    assign cycleRateOutput = st.cycleRate;
    assign workingReg = st.w;
    assign statusReg = st.status;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    // One step at a time, so a master clear arriving mid-cycle is not taken for a fault.
    property p_phase_order;
        !st.inClear |=> 2'(st.phase) == 2'(2'($past(st.phase)) + 2'h1);
    endproperty
    a_phase_order: assert property (p_phase_order) else $error("phase order broken");

    property p_fetch_step;
        st.phase == PHASE_FOUR && !st.inClear && !redirect |=> st.pc == $past(st.pc) + 12'h001;
    endproperty
    a_fetch_step: assert property (p_fetch_step) else $error("pc did not step");

    property p_flush;
        st.phase == PHASE_FOUR && !st.inClear && (redirect || skipNext) |=> !st.execValid;
    endproperty
    a_flush: assert property (p_flush) else $error("flow change not flushed");

    property p_w_phase;
        $changed(st.w) && !$past(st.inClear) |-> $past(st.phase) == PHASE_FOUR;
    endproperty
    a_w_phase: assert property (p_w_phase) else $error("accumulator written off phase");

    property p_read_phase;
        $changed(st.operand) |-> $past(st.phase) == PHASE_TWO;
    endproperty
    a_read_phase: assert property (p_read_phase) else $error("operand read off phase");

    property p_add_result;
        aluOp == ALU_ADD |-> {aluCarry, aluResult} == {1'b0, st.w} + {1'b0, st.operand};
    endproperty
    a_add_result: assert property (p_add_result) else $error("sum wrong");

    property p_sub_borrow;
        aluOp == ALU_SUB |-> aluCarry == (st.operand >= st.w)
            && aluNibble == (st.operand[NIB_W-1:0] >= st.w[NIB_W-1:0])
            && aluResult == st.operand - st.w;
    endproperty
    a_sub_borrow: assert property (p_sub_borrow) else $error("borrow flag wrong");

    property p_zero_flag;
        st.phase == PHASE_FOUR && st.execValid && setZ && !st.inClear
            |=> st.status[ST_ZERO] == ($past(aluResult) == '0);
    endproperty
    a_zero_flag: assert property (p_zero_flag) else $error("zero flag wrong");

    property p_cycle_rate;
        cycleRateOutput == (st.oscMode && (st.phase == PHASE_THREE || st.phase == PHASE_FOUR));
    endproperty
    a_cycle_rate: assert property (p_cycle_rate) else $error("cycle rate wrong");

    property p_clear;
        st.inClear |=> st.pc == '0 && !st.execValid && st.phase == PHASE_ONE;
    endproperty
    a_clear: assert property (p_clear) else $error("master clear ignored");

    c_add: cover property (st.phase == PHASE_FOUR && st.execValid && aluOp == ALU_ADD);
    c_skip: cover property (st.phase == PHASE_FOUR && st.execValid && skipNext);
    c_jump: cover property (st.phase == PHASE_FOUR && st.execValid && redirect);
    c_clear: cover property (st.inClear ##1 !st.inClear);

endmodule : exec_core

// File: verif/prog_rom.sv
`timescale 1ns/100ps
// ****************************************
// Program store model
// ****************************************
module prog_rom (
    input wire logic [core_pkg::PC_W-1:0] progAddr,
    output logic [core_pkg::INSN_W-1:0] progData
);
    import core_pkg::*;
    // The whole 4K space is modelled so that a stray fetch still returns a defined word.
    logic [INSN_W-1:0] mem [0:4095];
    initial begin
        for (int i = 0; i < 4096; i++) begin
            mem[i] = 14'h0000;
        end
    end
    // One whole 14-bit word per address, always driven by the store.
    assign progData = mem[progAddr];
endmodule : prog_rom

// File: verif/exec_core_tb.sv
`timescale 1ns/100ps
module exec_core_tb;
    import core_pkg::*;
    logic clk_sys;
    logic rst;
    logic masterClearN;
    logic resistorCapacitorOscMode;
    logic [INSN_W-1:0] progData;
    logic [PC_W-1:0] progAddr;
    logic cycleRateOutput;
    logic [DATA_W-1:0] workingReg;
    logic [DATA_W-1:0] statusReg;
    int err_total;
    int tests_run;
    int gapCnt;
    logic seen;
    logic [PC_W-1:0] lastAddr;

    exec_core i_dut (
        .clk_sys(clk_sys),
        .rst(rst),
        .masterClearN(masterClearN),
        .resistorCapacitorOscMode(resistorCapacitorOscMode),
        .progData(progData),
        .progAddr(progAddr),
        .cycleRateOutput(cycleRateOutput),
        .workingReg(workingReg),
        .statusReg(statusReg)
    );
    prog_rom i_rom (
        .progAddr(progAddr),
        .progData(progData)
    );

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // ****************************************
    // Checking and closing
    // ****************************************
    task automatic chk(input string name, input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : wrap_up

    // Fetches must come exactly one instruction cycle apart; a new start is ignored.
    always @(posedge clk_sys) begin
        if (rst || !masterClearN) begin
            seen <= 1'b0;
            gapCnt <= 0;
        end else begin
            gapCnt <= gapCnt + 1;
            if (progAddr !== lastAddr) begin
                if (seen) chk("fetch spacing", 16'(gapCnt), 16'h0004);
                seen <= 1'b1;
                gapCnt <= 1;
            end
        end
        lastAddr <= progAddr;
    end

    // ****************************************
    // Program runner
    // ****************************************
    task automatic run(input logic [13:0] w0, input logic [13:0] w1, input logic [13:0] w2,
                       input logic [13:0] w3, input logic [13:0] w4, input int halt);
        int n;
        @(negedge clk_sys);
        masterClearN = 1'b0;
        repeat (8) @(negedge clk_sys);
        chk("pc in clear", 16'(progAddr), 16'h0000);
        chk("acc in clear", 16'(workingReg), 16'h0000);
        i_rom.mem[0] = w0;
        i_rom.mem[1] = w1;
        i_rom.mem[2] = w2;
        i_rom.mem[3] = w3;
        i_rom.mem[4] = w4;
        masterClearN = 1'b1;
        n = 0;
        while (progAddr !== 12'(halt + 1) && n < 300) begin
            @(negedge clk_sys);
            n++;
        end
        chk("halt reached", 16'(n < 300), 16'h0001);
        repeat (16) @(negedge clk_sys);
    endtask : run

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_add_wrap();
        // Load 0xFF, add 1, store the zero result, loop.
        run(14'h30FF, 14'h3E01, 14'h00A0, 14'h2003, 14'h0000, 3);
        chk("add result", 16'(workingReg), 16'h0000);
        chk("add flags", 16'(statusReg[2:0]), 16'h0007);
    endtask : t_add_wrap

    task automatic t_sub_borrow();
        // 3 - 5 borrows from both nibbles; then increment a file copy into the accumulator.
        run(14'h3005, 14'h3C03, 14'h00A1, 14'h0A21, 14'h2004, 4);
        chk("inc of file", 16'(workingReg), 16'h00FF);
        chk("borrow flags", 16'(statusReg[2:0]), 16'h0000);
    endtask : t_sub_borrow

    task automatic t_sub_equal();
        // 0x10 - 0x10 has no borrow and a zero result.
        run(14'h3010, 14'h3C10, 14'h2002, 14'h0000, 14'h0000, 2);
        chk("sub zero", 16'(workingReg), 16'h0000);
        chk("no borrow flags", 16'(statusReg[2:0]), 16'h0007);
    endtask : t_sub_equal

    task automatic t_ram_kept();
        // Data memory survives a master clear; read back the stored difference.
        run(14'h0821, 14'h3AFE, 14'h2002, 14'h0000, 14'h0000, 2);
        chk("xor to zero", 16'(workingReg), 16'h0000);
        chk("zero flag", 16'(statusReg[ST_ZERO]), 16'h0001);
        // Write the status byte through its file address, then read it into the accumulator.
        run(14'h3001, 14'h0083, 14'h0803, 14'h2003, 14'h0000, 3);
        chk("status by file", 16'(workingReg), 16'h0001);
    endtask : t_ram_kept

    task automatic t_indirect_bits();
        // Point at the first bank-one byte, set its top bit indirectly, rotate it into W.
        run(14'h30A0, 14'h0084, 14'h1780, 14'h0D00, 14'h2004, 4);
        chk("rotate of file", 16'(workingReg), 16'h0000);
        chk("rotate carry", 16'(statusReg[2:0]), 16'h0001);
        // A clear zero flag skips the move, so only the added literal lands in W.
        run(14'h1903, 14'h3055, 14'h3E11, 14'h2003, 14'h0000, 3);
        chk("skip taken", 16'(workingReg), 16'h0011);
    endtask : t_indirect_bits

    task automatic t_cycle_rate();
        logic [7:0] bits;
        resistorCapacitorOscMode = 1'b1;
        repeat (10) @(negedge clk_sys);
        for (int i = 0; i < 8; i++) begin
            bits[i] = cycleRateOutput;
            @(negedge clk_sys);
        end
        chk("rate ones", 16'($countones(bits)), 16'h0004);
        chk("rate period", 16'(bits[3:0]), 16'(bits[7:4]));
        chk("rate halves", 16'(bits[3:0] == 4'h3 || bits[3:0] == 4'hC ||
            bits[3:0] == 4'h6 || bits[3:0] == 4'h9), 16'h0001);
        resistorCapacitorOscMode = 1'b0;
        repeat (10) @(negedge clk_sys);
        for (int i = 0; i < 8; i++) begin
            chk("rate off", 16'(cycleRateOutput), 16'h0000);
            @(negedge clk_sys);
        end
    endtask : t_cycle_rate

    initial begin
        err_total = 0;
        tests_run = 0;
        rst = 1'b1;
        masterClearN = 1'b1;
        resistorCapacitorOscMode = 1'b0;
        repeat (16) @(negedge clk_sys);
        rst = 1'b0;
        repeat (8) @(negedge clk_sys);
        t_add_wrap();
        t_sub_borrow();
        t_sub_equal();
        t_ram_kept();
        t_indirect_bits();
        t_cycle_rate();
        wrap_up();
    end

    // The whole sequence needs a few hundred cycles; this span leaves ample margin.
    initial begin
        #200000;
        err_total++;
        wrap_up();
    end
endmodule : exec_core_tb
